// ### hdl/sfr_read_path.v
// serial flash main array read path: opcode decode, address, data stream
`timescale 1ns/1ps
`include "sfr_defines.vh"
module sfr_read_path #(
	parameter PAGE_BITS = `SFR_DEF_PAGE_BITS
) (
	input wire CLK,
	input wire RST_N,
	input wire SCK,
	input wire CS_N,
	input wire SI,
	output reg SO_O,
	output reg SO_OE,
	input wire PAGE_528,
	input wire LOAD_EN,
	input wire [PAGE_BITS+`SFR_BYTE_BITS-1:0] LOAD_ADDR,
	input wire [7:0] LOAD_DATA
);
	localparam AW = PAGE_BITS + `SFR_BYTE_BITS;
	localparam DEPTH = (1 << PAGE_BITS) * 528;
	localparam ST_HEADER = 2'h0;
	localparam ST_DATA = 2'h1;
	localparam ST_IGNORE = 2'h2;

	reg sck_s1, sck_s2, sck_s3;
	reg cs_s1, cs_s2;
	reg si_s1, si_s2;
	reg page_s1, page_s2;
	reg [1:0] state_reg;
	reg [6:0] cnt_reg;
	reg [31:0] hdr_reg;
	reg [2:0] dummy_reg;
	reg page_mode_reg;
	reg [PAGE_BITS-1:0] page_reg;
	reg [9:0] byte_reg;
	reg [2:0] bit_reg;
	reg [6:0] shift_reg;
	reg fetch_reg;
	wire sck_rise;
	wire sck_fall;
	wire [23:0] addr_field;
	wire [9:0] page_len;
	wire [6:0] hdr_last;
	wire [7:0] rd_data;
	wire [AW-1:0] rd_index;
	wire [31:0] rd_index_full;

	// returns dummy byte count of a supported opcode, 7 when unsupported
	function [2:0] dummy_of;
		input [7:0] op;
		begin
			case (op)
				`SFR_OP_TOP_READ: dummy_of = `SFR_DUMMY_TOP;
				`SFR_OP_FAST_READ: dummy_of = `SFR_DUMMY_FAST;
				`SFR_OP_SLOW_READ: dummy_of = `SFR_DUMMY_NONE;
				`SFR_OP_LOW_POWER_READ: dummy_of = `SFR_DUMMY_NONE;
				`SFR_OP_PAGE_READ: dummy_of = `SFR_DUMMY_PAGE;
				default: dummy_of = 3'h7;
			endcase
		end
	endfunction

	// -----------------------------------------------------------------
	// pin synchronisers
	// -----------------------------------------------------------------
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sck_s1 <= 1'b0;
			sck_s2 <= 1'b0;
			sck_s3 <= 1'b0;
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			si_s1 <= 1'b0;
			si_s2 <= 1'b0;
			page_s1 <= 1'b1;
			page_s2 <= 1'b1;
		end else begin
			sck_s1 <= SCK;
			sck_s2 <= sck_s1;
			sck_s3 <= sck_s2;
			cs_s1 <= CS_N;
			cs_s2 <= cs_s1;
			si_s1 <= SI;
			si_s2 <= si_s1;
			page_s1 <= PAGE_528;
			page_s2 <= page_s1;
		end
	end

	// mode 0/3: sample on rising edge, shift out on falling edge
	assign sck_rise = sck_s2 & ~sck_s3;
	assign sck_fall = ~sck_s2 & sck_s3;

	// msb first: the last address bit joins the low end
	assign addr_field = {hdr_reg[22:0], si_s2};
	// page length follows the static size input
	assign page_len = page_s2 ? `SFR_PAGE_LEN_528 : `SFR_PAGE_LEN_512;
	assign hdr_last = `SFR_HEADER_BITS - 7'h01 + {1'b0, dummy_reg, 3'h0};
	// storage stride is the long page in both page modes
	assign rd_index_full = page_reg * `SFR_PAGE_LEN_528 + byte_reg;
	assign rd_index = rd_index_full[AW-1:0];

	// -----------------------------------------------------------------
	// command sequencer
	// -----------------------------------------------------------------
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_reg <= ST_HEADER;
			cnt_reg <= 7'h00;
			hdr_reg <= 32'h00000000;
			dummy_reg <= 3'h0;
			page_mode_reg <= 1'b0;
			page_reg <= {PAGE_BITS{1'b0}};
			byte_reg <= 10'h000;
			bit_reg <= 3'h0;
			shift_reg <= 7'h00;
			fetch_reg <= 1'b0;
			SO_O <= 1'b0;
			SO_OE <= 1'b0;
		end else if (cs_s2) begin
			// deselect ends the command and floats the output
			state_reg <= ST_HEADER;
			cnt_reg <= 7'h00;
			bit_reg <= 3'h0;
			fetch_reg <= 1'b0;
			SO_OE <= 1'b0;
		end else begin
			fetch_reg <= 1'b0;
			case (state_reg)
				ST_HEADER: begin
					if (sck_rise) begin
						cnt_reg <= cnt_reg + 7'h01;
						if (cnt_reg < `SFR_HEADER_BITS) begin
							hdr_reg <= {hdr_reg[30:0], si_s2};
						end
						if (cnt_reg == `SFR_OPCODE_BITS - 7'h01) begin
							dummy_reg <= dummy_of({hdr_reg[6:0], si_s2});
							page_mode_reg <= ({hdr_reg[6:0], si_s2} == `SFR_OP_PAGE_READ);
							if (dummy_of({hdr_reg[6:0], si_s2}) == 3'h7) begin
								state_reg <= ST_IGNORE;
							end
						end
						if (cnt_reg == `SFR_HEADER_BITS - 7'h01) begin
							// page and byte split by page size
							if (page_s2) begin
								page_reg <= addr_field[`SFR_BYTE_BITS+PAGE_BITS-1:`SFR_BYTE_BITS];
								byte_reg <= addr_field[9:0];
							end else begin
								page_reg <= addr_field[`SFR_BYTE_BITS+PAGE_BITS-2:`SFR_BYTE_BITS-1];
								byte_reg <= {1'b0, addr_field[8:0]};
							end
						end
						// data starts after header and dummies
						if (cnt_reg == hdr_last) begin
							state_reg <= ST_DATA;
							fetch_reg <= 1'b1;
						end
					end
				end
				ST_DATA: begin
					SO_OE <= 1'b1;
					// one bit per falling clock edge
					if (sck_fall) begin
						bit_reg <= bit_reg + 3'h1;
						if (bit_reg == 3'h0) begin
							SO_O <= rd_data[7];
							shift_reg <= rd_data[6:0];
							fetch_reg <= 1'b1;
							if (byte_reg >= page_len - 10'h001) begin
								byte_reg <= 10'h000;
								// page read stays on its page
								if (!page_mode_reg) begin
									// next page, array end wraps to zero
									page_reg <= page_reg + 1'b1;
								end
							end else begin
								byte_reg <= byte_reg + 10'h001;
							end
						end else begin
							SO_O <= shift_reg[6];
							shift_reg <= {shift_reg[5:0], 1'b0};
						end
					end
				end
				ST_IGNORE: begin
					SO_OE <= 1'b0;
				end
				default: begin
					state_reg <= ST_HEADER;
				end
			endcase
		end
	end

	// the read path reads the array and passes the load port through to it; it owns no buffer
	sfr_array_store #(
		.AW(AW),
		.DEPTH(DEPTH)
	) u_store (
		.clk(CLK),
		.rd_en(fetch_reg),
		.rd_addr(rd_index),
		.rd_data(rd_data),
		.ld_en(LOAD_EN),
		.ld_addr(LOAD_ADDR),
		.ld_data(LOAD_DATA)
	);
endmodule // sfr_read_path

// ### hdl/sfr_defines.vh
// constants of the serial flash array read path
`ifndef SFR_DEFINES_VH
`define SFR_DEFINES_VH

// -----------------------------------------------------------------
// opcodes
// -----------------------------------------------------------------
`define SFR_OP_TOP_READ 8'h1B
`define SFR_OP_FAST_READ 8'h0B
`define SFR_OP_SLOW_READ 8'h03
`define SFR_OP_LOW_POWER_READ 8'h01
`define SFR_OP_PAGE_READ 8'hD2

// -----------------------------------------------------------------
// dummy bytes per opcode
// -----------------------------------------------------------------
`define SFR_DUMMY_TOP 3'h2
`define SFR_DUMMY_FAST 3'h1
`define SFR_DUMMY_NONE 3'h0
`define SFR_DUMMY_PAGE 3'h4

// -----------------------------------------------------------------
// header layout and page geometry
// -----------------------------------------------------------------
`define SFR_OPCODE_BITS 7'h08
`define SFR_HEADER_BITS 7'h20
`define SFR_PAGE_LEN_528 10'h210
`define SFR_PAGE_LEN_512 10'h200
`define SFR_BYTE_BITS 10
`define SFR_DEF_PAGE_BITS 12

`endif

// ### hdl/sfr_array_store.v
// main array storage with registered read port and load port
`timescale 1ns/1ps
module sfr_array_store #(
	parameter AW = 22,
	parameter DEPTH = 2162688
) (
	input wire clk,
	input wire rd_en,
	input wire [AW-1:0] rd_addr,
	output reg [7:0] rd_data,
	input wire ld_en,
	input wire [AW-1:0] ld_addr,
	input wire [7:0] ld_data
);
	reg [7:0] mem [0:DEPTH-1];

	// -----------------------------------------------------------------
	// read and load ports
	// -----------------------------------------------------------------
	always @(posedge clk) begin
		if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
		if (ld_en) begin
			mem[ld_addr] <= ld_data;
		end
	end
endmodule // sfr_array_store

// ### tb/sfr_read_path_assertions.sv
// port checker of the read path
`timescale 1ns/1ps
module sfr_read_path_chk (
	input wire CLK,
	input wire RST_N,
	input wire SCK,
	input wire CS_N,
	input wire SO_O,
	input wire SO_OE
);
	// -------------------------------------------------------------
	// serial clock rises since select fell
	// -------------------------------------------------------------
	reg sck_reg;
	reg [6:0] cnt_reg;
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sck_reg <= 1'b0;
			cnt_reg <= 7'h00;
		end else begin
			sck_reg <= SCK;
			if (CS_N)
				cnt_reg <= 7'h00;
			else if (SCK && !sck_reg && cnt_reg != 7'h7F)
				cnt_reg <= cnt_reg + 7'h01;
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	property p_cs_end; $rose(CS_N) |-> ##[0:4] !SO_OE; endproperty
	a_cs_end: assert property (p_cs_end) else $error("oe after select");
	property p_cs_idle; CS_N[*5] |-> !SO_OE; endproperty
	a_cs_idle: assert property (p_cs_idle) else $error("oe while idle");
	property p_bit_fall; $changed(SO_O) && SO_OE && $past(SO_OE) |-> !$past(SCK, 3); endproperty
	a_bit_fall: assert property (p_bit_fall) else $error("so moved off fall");
	property p_oe_rise; $rose(SO_OE) |-> !CS_N && $past(SCK, 2); endproperty
	a_oe_rise: assert property (p_oe_rise) else $error("oe rose off edge");
	property p_hdr_len; $rose(SO_OE) |-> cnt_reg inside {7'h20, 7'h28, 7'h30, 7'h40}; endproperty
	a_hdr_len: assert property (p_hdr_len) else $error("bad header length");
	property p_no_early; ((!CS_N)[*5] ##0 cnt_reg < 7'h20) |-> !SO_OE; endproperty
	a_no_early: assert property (p_no_early) else $error("oe in header");
	property p_oe_hold; (!CS_N)[*5] ##0 SO_OE |=> SO_OE; endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("oe dropped");
	property p_rst_quiet; $rose(RST_N) |-> !SO_OE && !SO_O; endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("busy after reset");
endmodule // sfr_read_path_chk
bind sfr_read_path sfr_read_path_chk u_chk (.CLK(CLK), .RST_N(RST_N), .SCK(SCK),
	.CS_N(CS_N), .SO_O(SO_O), .SO_OE(SO_OE));

// ### tb/sfr_host.sv
// host serial master model, modes 0 and 3, 125 ns clock
`timescale 1ns/1ps
module sfr_host (
	output reg SCK,
	output reg CS_N,
	output reg SI,
	input wire SO_O,
	input wire CPOL
);
	initial begin
		SCK = 1'b0;
		CS_N = 1'b1;
		SI = 1'b0;
	end
	// held select, msb first, idle clock level from CPOL
	task xfer(input [7:0] d, output [7:0] q);
		integer i;
		begin
			if (CS_N) begin
				SCK = CPOL;
				#62.5 CS_N = 1'b0;
			end
			for (i = 7; i >= 0; i = i - 1) begin
				if (CPOL) begin
					#62.5 SCK = 1'b0;
				end
				SI = d[i];
				#62.5 SCK = 1'b1;
				q[i] = SO_O;
				if (!CPOL) begin
					#62.5 SCK = 1'b0;
				end
			end
		end
	endtask
	task stop;
		begin
			#62.5 CS_N = 1'b1;
			SI = ~SI;
		end
	endtask
endmodule // sfr_host

// ### tb/tb_sfr_read_path.sv
// self-checking bench of the read path
`timescale 1ns/1ps
`include "sfr_defines.vh"
module tb_sfr_read_path;
	localparam PB = 4;
	localparam N = 16 * 528;
	reg CLK = 1'b0;
	reg RST_N = 1'b0;
	reg PAGE_528 = 1'b1;
	reg LOAD_EN = 1'b0;
	reg [PB+9:0] LOAD_ADDR = 14'h0000;
	reg [7:0] LOAD_DATA = 8'h00;
	wire SCK, CS_N, SI, SO_O, SO_OE;
	wire so_line;
	reg cpol = 1'b0;
	// floating line reads inverted, so a sample taken without drive fails
	assign so_line = SO_OE ? SO_O : ~SO_O;
	reg [7:0] mem [0:N-1];
	reg [31:0] seed = 32'h00015B1B;
	integer mismatches = 0;
	integer check_count = 0;
	integer k, i, j, pg, by, ln, nd;
	reg [7:0] op, q;
	reg [23:0] ad;
	always #5 CLK = ~CLK;
	sfr_read_path #(.PAGE_BITS(PB)) u_dut (.CLK(CLK), .RST_N(RST_N), .SCK(SCK), .CS_N(CS_N),
		.SI(SI), .SO_O(SO_O), .SO_OE(SO_OE), .PAGE_528(PAGE_528), .LOAD_EN(LOAD_EN),
		.LOAD_ADDR(LOAD_ADDR), .LOAD_DATA(LOAD_DATA));
	sfr_host u_host (.SCK(SCK), .CS_N(CS_N), .SI(SI), .SO_O(so_line), .CPOL(cpol));
	function [31:0] rnd(input [31:0] s);
		reg [31:0] x;
		begin
			x = s ^ (s << 13);
			x = x ^ (x >> 17);
			rnd = x ^ (x << 5);
		end
	endfunction
	task chk(input [7:0] got, input [7:0] exp);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				mismatches = mismatches + 1;
				$display("wrong value at %0t: got %h want %h", $time, got, exp);
			end
		end
	endtask
	task chk_oe(input got);
		begin
			check_count = check_count + 1;
			if (got !== 1'b0) begin
				mismatches = mismatches + 1;
				$display("wrong value at %0t: output driven, want floating", $time);
			end
		end
	endtask
	// linear storage index of a page and byte
	function integer idx(input integer p, input integer b);
		begin
			idx = p * `SFR_PAGE_LEN_528 + b;
		end
	endfunction
	task conclude;
		begin
			if (mismatches == 0 && check_count > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	initial begin
		repeat (6) @(posedge CLK);
		RST_N <= 1'b1;
		for (i = 0; i < N; i = i + 1) begin
			seed = rnd(seed);
			mem[i] = seed[7:0];
			@(posedge CLK);
			LOAD_EN <= 1'b1;
			LOAD_ADDR <= i[PB+9:0];
			LOAD_DATA <= seed[7:0];
		end
		@(posedge CLK) LOAD_EN <= 1'b0;
		for (k = 0; k < 12; k = k + 1) begin
			@(posedge CLK) PAGE_528 <= (k < 6);
			cpol <= k[1];
			case (k % 6)
			0: begin op = `SFR_OP_TOP_READ; nd = 2; end
			1: begin op = `SFR_OP_FAST_READ; nd = 1; end
			2: begin op = `SFR_OP_SLOW_READ; nd = 0; end
			3: begin op = `SFR_OP_LOW_POWER_READ; nd = 0; end
			4: begin op = `SFR_OP_PAGE_READ; nd = 4; end
			default: begin op = 8'h77; nd = 0; end
			endcase
			seed = rnd(seed);
			ln = (k < 6) ? 528 : 512;
			pg = (k % 3 == 0) ? 15 : seed[3:0];
			by = (k % 2 == 0) ? ln - 2 : seed[19:8] % ln;
			ad = (k < 6) ? {seed[31:30], pg[11:0], by[9:0]} : {seed[31:29], pg[11:0], by[8:0]};
			// phase the link so no pin edge lands on a clock edge
			#6;
			u_host.xfer(op, q);
			u_host.xfer(ad[23:16], q);
			u_host.xfer(ad[15:8], q);
			u_host.xfer(ad[7:0], q);
			for (j = 0; j < nd; j = j + 1)
				u_host.xfer(seed[27:20], q);
			for (j = 0; j < 3; j = j + 1) begin
				u_host.xfer(seed[15:8], q);
				if (op == 8'h77)
					chk_oe(SO_OE);
				else
					chk(q, mem[idx(pg, by)]);
				by = by + 1;
				if (by == ln) begin
					by = 0;
					if (op != `SFR_OP_PAGE_READ)
						pg = (pg + 1) % 16;
				end
			end
			u_host.stop;
			repeat (5) @(negedge CLK);
			chk_oe(SO_OE);
		end
		conclude;
	end
endmodule // tb_sfr_read_path
